// ### design/io_decode_pkg.sv
// shared constants and option types for the host i/o decoder
package io_decode_pkg;

  localparam int ADDR_W = 16;
  localparam int IRQ_W  = 16;

  // chip select window bases
  localparam logic [ADDR_W-1:0] CS_BASE_110 = 16'h0110;
  localparam logic [ADDR_W-1:0] CS_BASE_220 = 16'h0220;
  localparam logic [ADDR_W-1:0] CS_BASE_340 = 16'h0340;

  // legacy port bases
  localparam logic [ADDR_W-1:0] COM_BASE_3F8 = 16'h03f8;
  localparam logic [ADDR_W-1:0] COM_BASE_2F8 = 16'h02f8;
  localparam logic [ADDR_W-1:0] COM_BASE_3E8 = 16'h03e8;
  localparam logic [ADDR_W-1:0] COM_BASE_2E8 = 16'h02e8;
  localparam logic [ADDR_W-1:0] LPT_BASE_378 = 16'h0378;
  localparam logic [ADDR_W-1:0] LPT_BASE_278 = 16'h0278;
  localparam logic [ADDR_W-1:0] LPT_BASE_3BC = 16'h03bc;
  localparam logic [ADDR_W-1:0] EXT_CFG_BASE = 16'h0370;

  // window sizes as log2 of the byte count
  localparam logic [1:0] COM_SPAN_LOG2    = 2'h3;
  localparam logic [1:0] LPT_SPAN_LOG2    = 2'h3;
  localparam logic [1:0] LPT_3BC_LOG2     = 2'h2;
  localparam logic [1:0] EXT_CFG_LOG2     = 2'h1;

  // interrupt line numbers
  localparam logic [3:0] IRQ_3  = 4'h3;
  localparam logic [3:0] IRQ_4  = 4'h4;
  localparam logic [3:0] IRQ_5  = 4'h5;
  localparam logic [3:0] IRQ_7  = 4'h7;
  localparam logic [3:0] IRQ_9  = 4'h9;
  localparam logic [3:0] IRQ_10 = 4'ha;
  localparam logic [3:0] IRQ_11 = 4'hb;

  typedef enum logic [1:0] {CS_DIS, CS_110, CS_220, CS_340} cs_base_t;
  typedef enum logic [1:0] {CS_SIZE_1, CS_SIZE_2, CS_SIZE_4, CS_SIZE_8} cs_size_t;
  typedef enum logic [2:0] {COM_DIS, COM_3F8_4, COM_2F8_3, COM_3E8_4, COM_2E8_3} com_sel_t;
  typedef enum logic [1:0] {LPT_DIS, LPT_378, LPT_278, LPT_3BC} lpt_base_t;
  typedef enum logic [2:0] {LPT_COMPAT, LPT_BIDIR, LPT_EPP17, LPT_EPP19, LPT_ECP} lpt_mode_t;
  typedef enum logic [2:0] {LPT_IRQ_DIS, LPT_IRQ5, LPT_IRQ7, LPT_IRQ9, LPT_IRQ10, LPT_IRQ11} lpt_irq_t;

  // reset defaults of the option registers
  localparam cs_base_t  CS_BASE_RST  = CS_DIS;
  localparam cs_size_t  CS_SIZE_RST  = CS_SIZE_1;
  localparam com_sel_t  COM1_RST     = COM_3F8_4;
  localparam com_sel_t  COM2_RST     = COM_2F8_3;
  localparam lpt_base_t LPT_BASE_RST = LPT_DIS;
  localparam lpt_mode_t LPT_MODE_RST = LPT_COMPAT;
  localparam lpt_irq_t  LPT_IRQ_RST  = LPT_IRQ_DIS;

endpackage : io_decode_pkg

// ### design/io_window_match.sv
// address window comparator: base plus power of two span
`timescale 1ns/100ps
module io_window_match (
  // window
  input  wire logic                              en_i,
  input  wire logic [io_decode_pkg::ADDR_W-1:0] base_i,
  input  wire logic [1:0]                        span_log2_i,
  // address under test
  input  wire logic [io_decode_pkg::ADDR_W-1:0] addr_i,
  output logic                                   hit_o
);
  import io_decode_pkg::*;

  logic [ADDR_W-1:0] mask;

  // only the byte-select bits inside the window are ignored
  always_comb begin
    mask  = {ADDR_W{1'b1}} << span_log2_i;
    hit_o = en_i && (((addr_i ^ base_i) & mask) == '0);
  end

endmodule : io_window_match

// ### design/io_decode.sv
// host i/o chip select, legacy port decode, irq and dma request steering
`timescale 1ns/100ps
// Functional notes
// - chip select base 110/220/340, default disabled
// - chip select window of 1,2,4,8 bytes
// - assert chip select on cycles inside window
// - serial 1 at 3F8/3E8 irq4, 2F8/2E8 irq3
// - serial 2 same choices, default 2F8 irq3
// - floppy and parallel port never share pins
// - parallel at 378/278/3BC, needs floppy disabled
// - parallel mode compatible, bidir, epp17, epp19, ecp
// - parallel irq 5,7,9,10,11 or disabled
// - dma request to on-board controller or bridge
module io_decode (
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  // host i/o cycle
  input  wire logic                              io_cycle_i,
  input  wire logic [io_decode_pkg::ADDR_W-1:0] io_addr_i,
  // options
  input  wire io_decode_pkg::cs_base_t           cs_base_i,
  input  wire io_decode_pkg::cs_size_t           cs_size_i,
  input  wire io_decode_pkg::com_sel_t           com1_sel_i,
  input  wire io_decode_pkg::com_sel_t           com2_sel_i,
  input  wire io_decode_pkg::lpt_base_t          lpt_base_i,
  input  wire io_decode_pkg::lpt_mode_t          lpt_mode_i,
  input  wire io_decode_pkg::lpt_irq_t           lpt_irq_i,
  input  wire logic                              floppy_en_i,
  input  wire logic                              dma_to_bridge_i,
  // interrupt and dma sources
  input  wire logic                              com1_irq_i,
  input  wire logic                              com2_irq_i,
  input  wire logic                              lpt_irq_req_i,
  input  wire logic                              dma_request_line_i,
  // selects
  output logic                                   general_purpose_chip_select_o,
  output logic                                   com1_sel_o,
  output logic                                   com2_sel_o,
  output logic                                   lpt_sel_o,
  output logic                                   ext_cfg_sel_o,
  // routing
  output logic [io_decode_pkg::IRQ_W-1:0]       irq_o,
  output logic                                   sio_dma_request_line_o,
  output logic                                   isa_dma_request_line_o,
  output logic                                   floppy_pins_own_o,
  output logic                                   lpt_pins_own_o,
  output io_decode_pkg::lpt_mode_t               lpt_mode_o
);
  import io_decode_pkg::*;

  typedef struct packed {
    cs_base_t          cs_base;
    cs_size_t          cs_size;
    com_sel_t          com1;
    com_sel_t          com2;
    lpt_base_t         lpt_base;
    lpt_mode_t         lpt_mode;
    lpt_irq_t          lpt_irq;
    logic              floppy_en;
    logic              dma_to_bridge;
    logic              gp_cs;
    logic              com1_hit;
    logic              com2_hit;
    logic              lpt_hit;
    logic              ext_hit;
    logic [IRQ_W-1:0]  irq;
    logic              dma_sio;
    logic              dma_isa;
  } state_t;

  localparam state_t STATE_RST = '{
    cs_base: CS_BASE_RST, cs_size: CS_SIZE_RST, com1: COM1_RST, com2: COM2_RST,
    lpt_base: LPT_BASE_RST, lpt_mode: LPT_MODE_RST, lpt_irq: LPT_IRQ_RST,
    floppy_en: 1'b1, dma_to_bridge: 1'b0, gp_cs: 1'b0, com1_hit: 1'b0,
    com2_hit: 1'b0, lpt_hit: 1'b0, ext_hit: 1'b0, irq: '0, dma_sio: 1'b0,
    dma_isa: 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [ADDR_W-1:0] com_base(input com_sel_t sel);
    unique case (sel)
      COM_3F8_4: com_base = COM_BASE_3F8;
      COM_2F8_3: com_base = COM_BASE_2F8;
      COM_3E8_4: com_base = COM_BASE_3E8;
      COM_2E8_3: com_base = COM_BASE_2E8;
      default:   com_base = '0;
    endcase
  endfunction : com_base
  function automatic logic [IRQ_W-1:0] com_irq(input com_sel_t sel, input logic req);
    logic [3:0] num;
    num = IRQ_3;
    unique case (sel)
      COM_3F8_4, COM_3E8_4: num = IRQ_4;
      COM_2F8_3, COM_2E8_3: num = IRQ_3;
      default:              num = IRQ_3;
    endcase
    com_irq = (req && sel != COM_DIS) ? (IRQ_W'(1) << num) : '0;
  endfunction : com_irq
  function automatic logic [ADDR_W-1:0] cs_base_addr(input cs_base_t sel);
    unique case (sel)
      CS_110:  cs_base_addr = CS_BASE_110;
      CS_220:  cs_base_addr = CS_BASE_220;
      CS_340:  cs_base_addr = CS_BASE_340;
      default: cs_base_addr = '0;
    endcase
  endfunction : cs_base_addr

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_pipe_reg;
  logic       rst_sync_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // window comparators

  state_t            state_reg;
  state_t            state_next;
  logic              lpt_active;
  logic [ADDR_W-1:0] lpt_base_addr;
  logic [1:0]        lpt_span;
  logic              cs_hit;
  logic              com1_hit;
  logic              com2_hit;
  logic              lpt_hit;
  logic              ext_hit;
  // parallel port pins are only handed over once the floppy lets go
  assign lpt_active = (state_reg.lpt_base != LPT_DIS) && !state_reg.floppy_en;
  always_comb begin
    lpt_base_addr = LPT_BASE_378;
    lpt_span      = LPT_SPAN_LOG2;
    unique case (state_reg.lpt_base)
      LPT_278: lpt_base_addr = LPT_BASE_278;
      LPT_3BC: begin
        lpt_base_addr = LPT_BASE_3BC;
        lpt_span      = LPT_3BC_LOG2;
      end
      default: lpt_base_addr = LPT_BASE_378;
    endcase
  end

  io_window_match u_cs_win (
    .en_i        (state_reg.cs_base != CS_DIS),
    .base_i      (cs_base_addr(state_reg.cs_base)),
    .span_log2_i (state_reg.cs_size),
    .addr_i      (io_addr_i),
    .hit_o       (cs_hit)
  );
  io_window_match u_com1_win (
    .en_i        (state_reg.com1 != COM_DIS),
    .base_i      (com_base(state_reg.com1)),
    .span_log2_i (COM_SPAN_LOG2),
    .addr_i      (io_addr_i),
    .hit_o       (com1_hit)
  );
  io_window_match u_com2_win (
    .en_i        (state_reg.com2 != COM_DIS),
    .base_i      (com_base(state_reg.com2)),
    .span_log2_i (COM_SPAN_LOG2),
    .addr_i      (io_addr_i),
    .hit_o       (com2_hit)
  );
  io_window_match u_lpt_win (
    .en_i        (lpt_active),
    .base_i      (lpt_base_addr),
    .span_log2_i (lpt_span),
    .addr_i      (io_addr_i),
    .hit_o       (lpt_hit)
  );
  // external controller answers its config pair at 370/371
  io_window_match u_ext_win (
    .en_i        (1'b1),
    .base_i      (EXT_CFG_BASE),
    .span_log2_i (EXT_CFG_LOG2),
    .addr_i      (io_addr_i),
    .hit_o       (ext_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] lpt_num;
    lpt_num                  = IRQ_5;
    state_next               = state_reg;
    state_next.cs_base       = cs_base_i;
    state_next.cs_size       = cs_size_i;
    state_next.com1          = com1_sel_i;
    state_next.com2          = com2_sel_i;
    state_next.lpt_base      = lpt_base_i;
    state_next.lpt_mode      = lpt_mode_i;
    state_next.lpt_irq       = lpt_irq_i;
    state_next.floppy_en     = floppy_en_i;
    state_next.dma_to_bridge = dma_to_bridge_i;
    state_next.gp_cs         = io_cycle_i && cs_hit;
    state_next.com1_hit      = io_cycle_i && com1_hit;
    state_next.com2_hit      = io_cycle_i && com2_hit;
    state_next.lpt_hit       = io_cycle_i && lpt_hit;
    state_next.ext_hit       = io_cycle_i && ext_hit;
    unique case (state_reg.lpt_irq)
      LPT_IRQ7:  lpt_num = IRQ_7;
      LPT_IRQ9:  lpt_num = IRQ_9;
      LPT_IRQ10: lpt_num = IRQ_10;
      LPT_IRQ11: lpt_num = IRQ_11;
      default:   lpt_num = IRQ_5;
    endcase
    state_next.irq = com_irq(state_reg.com1, com1_irq_i) | com_irq(state_reg.com2, com2_irq_i);
    if (lpt_active && lpt_irq_req_i && state_reg.lpt_irq != LPT_IRQ_DIS) begin
      state_next.irq = state_next.irq | (IRQ_W'(1) << lpt_num);
    end
    // isa side dma only sees requests when the bridge is chosen
    state_next.dma_isa = dma_request_line_i && state_reg.dma_to_bridge;
    state_next.dma_sio = dma_request_line_i && !state_reg.dma_to_bridge;
  end

  always_ff @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign general_purpose_chip_select_o = state_reg.gp_cs;
  assign com1_sel_o                    = state_reg.com1_hit;
  assign com2_sel_o                    = state_reg.com2_hit;
  assign lpt_sel_o                     = state_reg.lpt_hit;
  assign ext_cfg_sel_o                 = state_reg.ext_hit;
  assign irq_o                         = state_reg.irq;
  assign sio_dma_request_line_o        = state_reg.dma_sio;
  assign isa_dma_request_line_o        = state_reg.dma_isa;
  assign floppy_pins_own_o             = state_reg.floppy_en;
  assign lpt_pins_own_o                = lpt_active;
  assign lpt_mode_o                    = state_reg.lpt_mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [ADDR_W:0] cs_lo;
  logic [ADDR_W:0] cs_hi;
  logic            cs_in_win;

  always_comb begin
    cs_lo     = {1'b0, cs_base_addr(state_reg.cs_base)};
    cs_hi     = cs_lo + ((ADDR_W+1)'(1) << state_reg.cs_size);
    cs_in_win = ({1'b0, io_addr_i} >= cs_lo) && ({1'b0, io_addr_i} < cs_hi);
  end

  a_cs_disabled_idle: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    state_reg.cs_base == CS_DIS |=> !general_purpose_chip_select_o)
    else $error("chip select while disabled");
  a_cs_window_hit: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    io_cycle_i && state_reg.cs_base != CS_DIS && cs_in_win |=> general_purpose_chip_select_o)
    else $error("chip select missed inside window");
  a_cs_outside_quiet: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    !(io_cycle_i && cs_in_win) |=> !general_purpose_chip_select_o)
    else $error("chip select outside window");
  a_com1_irq_route: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    state_reg.com1 == COM_3E8_4 && com1_irq_i |=> irq_o[IRQ_4])
    else $error("serial 1 irq not on line 4");
  a_com2_irq_route: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    state_reg.com2 == COM_2F8_3 && com2_irq_i |=> irq_o[IRQ_3])
    else $error("serial 2 irq not on line 3");
  a_pins_exclusive: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    !(floppy_pins_own_o && lpt_pins_own_o))
    else $error("floppy and parallel share pins");
  a_lpt_floppy_off: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    state_reg.floppy_en |=> !lpt_sel_o)
    else $error("parallel decoded with floppy on");
  a_lpt_mode_follow: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    lpt_mode_i == LPT_ECP ##1 lpt_mode_i == LPT_ECP |-> lpt_mode_o == LPT_ECP ##1 lpt_mode_o == LPT_ECP)
    else $error("parallel mode not applied");
  a_lpt_irq_route: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    lpt_active && state_reg.lpt_irq == LPT_IRQ9 && lpt_irq_req_i |=> irq_o[IRQ_9])
    else $error("parallel irq not on line 9");
  a_dma_steer: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    dma_request_line_i && !state_reg.dma_to_bridge |=> sio_dma_request_line_o && !isa_dma_request_line_o)
    else $error("dma request misrouted");
  a_ext_cfg_pair: assert property (@(posedge clk_i) disable iff (!rst_sync_n)
    io_cycle_i && (io_addr_i == EXT_CFG_BASE || io_addr_i == (EXT_CFG_BASE | 16'h0001)) |=> ext_cfg_sel_o)
    else $error("config port not decoded");

endmodule : io_decode

// ### tb/io_periph_model.sv
// carrier-side peripheral that answers the decoded selects
`timescale 1ns/100ps
module io_periph_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // selects seen from the decoder
  input  wire logic        cs_i,
  input  wire logic        cfg_sel_i,
  input  wire logic        onboard_floppy_i,
  // observation
  output logic [15:0]      cs_cnt_o,
  output logic [15:0]      cfg_cnt_o,
  output logic             ext_floppy_en_o,
  output logic [15:0]      ext_irq_o
);
  // external serial sits on line 11, external parallel on line 7;
  // line 11 is only free once pci routing has been moved off it
  localparam logic [15:0] EXT_COM_IRQ = 16'h0800;
  localparam logic [15:0] EXT_LPT_IRQ = 16'h0080;
  assign ext_irq_o = EXT_COM_IRQ | EXT_LPT_IRQ;
  // counts every cycle a select stands, so a stretched select shows up
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_cnt_o        <= 16'h0;
      cfg_cnt_o       <= 16'h0;
      ext_floppy_en_o <= 1'b0;
    end else begin
      if (cs_i) cs_cnt_o <= cs_cnt_o + 16'h1;
      if (cfg_sel_i) cfg_cnt_o <= cfg_cnt_o + 16'h1;
      ext_floppy_en_o <= !onboard_floppy_i;
    end
  end
endmodule : io_periph_model

// ### tb/io_decode_tb_top.sv
// self-checking bench for the host i/o decoder
`timescale 1ns/100ps
module io_decode_tb_top;
  import io_decode_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              io_cycle_i = 1'b1;
  logic [ADDR_W-1:0] io_addr_i = 16'h03f8;
  cs_base_t          cs_base_i = CS_DIS;
  cs_size_t          cs_size_i = CS_SIZE_1;
  com_sel_t          com1_sel_i = COM_3F8_4;
  com_sel_t          com2_sel_i = COM_2F8_3;
  lpt_base_t         lpt_base_i = LPT_DIS;
  lpt_mode_t         lpt_mode_i = LPT_COMPAT;
  lpt_irq_t          lpt_irq_i = LPT_IRQ_DIS;
  logic              floppy_en_i = 1'b1;
  logic              dma_to_bridge_i = 1'b0;
  logic              com1_irq_i = 1'b1;
  logic              com2_irq_i = 1'b1;
  logic              lpt_irq_req_i = 1'b1;
  logic              dma_i = 1'b1;
  logic              gp_cs, com1_sel, com2_sel, lpt_sel, ext_sel;
  logic [IRQ_W-1:0]  irq;
  logic              sio_dma, isa_dma, floppy_own, lpt_own, ext_floppy;
  lpt_mode_t         mode;
  logic [15:0]       cs_cnt, cfg_cnt, ext_irq;
  int                n_mismatch = 0, checks = 0, n_cs = 0, n_cfg = 0;

  always #25 clk_i = ~clk_i;

  io_decode uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .io_cycle_i(io_cycle_i), .io_addr_i(io_addr_i),
    .cs_base_i(cs_base_i), .cs_size_i(cs_size_i), .com1_sel_i(com1_sel_i), .com2_sel_i(com2_sel_i),
    .lpt_base_i(lpt_base_i), .lpt_mode_i(lpt_mode_i), .lpt_irq_i(lpt_irq_i),
    .floppy_en_i(floppy_en_i), .dma_to_bridge_i(dma_to_bridge_i), .com1_irq_i(com1_irq_i),
    .com2_irq_i(com2_irq_i), .lpt_irq_req_i(lpt_irq_req_i), .dma_request_line_i(dma_i),
    .general_purpose_chip_select_o(gp_cs), .com1_sel_o(com1_sel), .com2_sel_o(com2_sel),
    .lpt_sel_o(lpt_sel), .ext_cfg_sel_o(ext_sel), .irq_o(irq), .sio_dma_request_line_o(sio_dma),
    .isa_dma_request_line_o(isa_dma), .floppy_pins_own_o(floppy_own), .lpt_pins_own_o(lpt_own),
    .lpt_mode_o(mode));

  io_periph_model partner (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_i(gp_cs), .cfg_sel_i(ext_sel),
    .onboard_floppy_i(floppy_own), .cs_cnt_o(cs_cnt), .cfg_cnt_o(cfg_cnt), .ext_floppy_en_o(ext_floppy),
    .ext_irq_o(ext_irq));

  ////////////////////////////////////////
  task automatic step();
    @(posedge clk_i);
    #2;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [15:0] selv();
    return {11'h0, gp_cs, com1_sel, com2_sel, lpt_sel, ext_sel};
  endfunction : selv

  // one io cycle; select must stand for exactly the next cycle
  task automatic probe(input logic [15:0] a, input logic [4:0] e);
    io_cycle_i = 1'b1;
    io_addr_i = a;
    step();
    io_cycle_i = 1'b0;
    check(selv(), {11'h0, e});
    if (e[4]) n_cs++;
    if (e[0]) n_cfg++;
    step();
    check(selv(), 16'h0);
  endtask : probe

  task automatic test_done();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  ////////////////////////////////////////
  task automatic t_reset();
    repeat (3) step();
    check(selv(), 16'h0);
    check(irq, 16'h0);
    check({14'h0, sio_dma, isa_dma}, 16'h0);
    check({14'h0, floppy_own, lpt_own}, 16'h2);
    check({13'h0, mode}, {13'h0, LPT_COMPAT});
    rst_n_i = 1'b1;
    io_cycle_i = 1'b0;
    com1_irq_i = 1'b0;
    com2_irq_i = 1'b0;
    repeat (3) step();
  endtask : t_reset

  task automatic t_cs();
    logic [15:0] base [3] = '{16'h0110, 16'h0220, 16'h0340};
    logic [15:0] n;
    for (int b = 0; b < 3; b++) begin
      for (int s = 0; s < 4; s++) begin
        cs_base_i = cs_base_t'(b + 1);
        cs_size_i = cs_size_t'(s);
        step();
        n = 16'h1 << s;
        probe(base[b] + n - 16'h1, 5'h10);
        probe(base[b] + n, 5'h0);
        probe(base[b] - 16'h1, 5'h0);
        probe(base[b] ^ 16'h1000, 5'h0);
      end
      cs_base_i = CS_DIS;
      step();
      probe(base[b], 5'h0);
    end
  endtask : t_cs

  task automatic t_com();
    com_sel_t    sel [4] = '{COM_3F8_4, COM_2F8_3, COM_3E8_4, COM_2E8_3};
    logic [15:0] base [4] = '{16'h03f8, 16'h02f8, 16'h03e8, 16'h02e8};
    logic [15:0] line [4] = '{16'h0010, 16'h0008, 16'h0010, 16'h0008};
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        com1_sel_i = p ? COM_DIS : sel[k];
        com2_sel_i = p ? sel[k] : COM_DIS;
        step();
        probe(base[k], p ? 5'h04 : 5'h08);
        probe(base[k] + 16'h7, p ? 5'h04 : 5'h08);
        probe(base[k] + 16'h8, 5'h0);
        com1_irq_i = !p;
        com2_irq_i = p[0];
        step();
        check(irq, line[k]);
        check(irq & ext_irq, 16'h0);
        com1_irq_i = 1'b1;
        com2_irq_i = 1'b1;
        com1_sel_i = COM_DIS;
        com2_sel_i = COM_DIS;
        step();
        step();
        check(irq, 16'h0);
      end
    end
    com1_irq_i = 1'b0;
    com2_irq_i = 1'b0;
  endtask : t_com

  task automatic t_lpt();
    lpt_irq_t    ln [5] = '{LPT_IRQ5, LPT_IRQ7, LPT_IRQ9, LPT_IRQ10, LPT_IRQ11};
    logic [15:0] lv [5] = '{16'h0020, 16'h0080, 16'h0200, 16'h0400, 16'h0800};
    logic [15:0] base [3] = '{16'h0378, 16'h0278, 16'h03bc};
    lpt_base_i = LPT_378;
    lpt_irq_i = LPT_IRQ5;
    step();
    step();
    probe(16'h0378, 5'h0);
    check({14'h0, floppy_own, lpt_own}, 16'h2);
    check(irq, 16'h0);
    check({15'h0, ext_floppy}, 16'h0);
    floppy_en_i = 1'b0;
    step();
    step();
    check({14'h0, floppy_own, lpt_own}, 16'h1);
    check({15'h0, ext_floppy}, 16'h1);
    // the 3bc window is only four bytes wide
    for (int k = 0; k < 3; k++) begin
      lpt_base_i = lpt_base_t'(k + 1);
      step();
      probe(base[k] + (k == 2 ? 16'h3 : 16'h7), 5'h02);
      probe(base[k] + (k == 2 ? 16'h4 : 16'h8), 5'h0);
    end
    for (int k = 0; k < 5; k++) begin
      lpt_irq_i = ln[k];
      lpt_mode_i = lpt_mode_t'(k);
      step();
      step();
      check(irq, lv[k]);
      check({13'h0, mode}, 16'(k));
    end
    lpt_base_i = LPT_DIS;
    step();
    step();
    check(irq, 16'h0);
    check({14'h0, floppy_own, lpt_own}, 16'h0);
  endtask : t_lpt

  task automatic t_dma();
    for (int b = 0; b < 2; b++) begin
      dma_i = 1'b0;
      dma_to_bridge_i = b[0];
      step();
      check({14'h0, sio_dma, isa_dma}, 16'h0);
      dma_i = 1'b1;
      step();
      check({14'h0, sio_dma, isa_dma}, b ? 16'h1 : 16'h2);
    end
  endtask : t_dma

  ////////////////////////////////////////
  initial begin
    t_reset();
    t_cs();
    t_com();
    t_lpt();
    t_dma();
    probe(16'h0370, 5'h01);
    probe(16'h0371, 5'h01);
    probe(16'h0372, 5'h0);
    probe(16'h036f, 5'h0);
    check(cs_cnt, 16'(n_cs));
    check(cfg_cnt, 16'(n_cfg));
    test_done();
  end

  // generous bound: the whole run needs well under a thousand cycles
  initial begin
    #(5000 * 50);
    n_mismatch++;
    test_done();
  end
endmodule : io_decode_tb_top
